// *** include/bkr_consts.svh ***
// constants for the key, rop, clip and stipple block: offsets, fields, resets
`ifndef BKR_CONSTS_SVH
`define BKR_CONSTS_SVH

// register byte addresses
`define BKR_A_CLIP0LO   8'h00
`define BKR_A_CLIP0HI   8'h04
`define BKR_A_CLIP1LO   8'h08
`define BKR_A_CLIP1HI   8'h0C
`define BKR_A_SKEYLO    8'h10
`define BKR_A_SKEYHI    8'h14
`define BKR_A_DKEYLO    8'h18
`define BKR_A_DKEYHI    8'h1C
`define BKR_A_ROPS      8'h20
`define BKR_A_STYLE     8'h24
`define BKR_A_PATTERN   8'h28
`define BKR_A_FGCOL     8'h2C
`define BKR_A_BGCOL     8'h30
`define BKR_A_COMMAND   8'h34
`define BKR_A_STATUS    8'h38
`define BKR_A_OFFS      7:0
`define BKR_A_PAGE      31:8

// command register fields
`define BKR_CMD_ROP0    7:0
`define BKR_CMD_SKEYEN  8
`define BKR_CMD_DKEYEN  9
`define BKR_CMD_CLIPSEL 10
`define BKR_CMD_TRANSP  11
`define BKR_CMD_FMT     14:12
`define BKR_CMD_MASK    32'h00007FFF

// format codes
`define BKR_FMT_MONO    3'h0
`define BKR_FMT_8BPP    3'h1

// clip bound fields
`define BKR_CLIP_X      11:0
`define BKR_CLIP_Y      27:16
`define BKR_CLIP_MASK   32'h0FFF0FFF

// key bound field
`define BKR_KEY_MASK    32'h00FFFFFF
`define BKR_KEY_VAL     23:0

// rop register fields
`define BKR_ROP1        7:0
`define BKR_ROP2        15:8
`define BKR_ROP3        23:16
`define BKR_ROPS_MASK   32'h00FFFFFF

// stipple control fields
`define BKR_ST_REP      7:0
`define BKR_ST_SIZE     12:8
`define BKR_ST_FRAC     23:16
`define BKR_ST_INT      28:24
`define BKR_ST_MASK     32'h1FFF1FFF

// channel slices of a key comparison
`define BKR_CH_B        7:0
`define BKR_CH_G        15:8
`define BKR_CH_R        23:16

`define BKR_ZERO32      32'h00000000
`define BKR_HRESP_OKAY  1'b0

`endif

// *** include/bkr_pkg.sv ***
// types shared by the key, rop, clip and stipple block
`default_nettype none
package bkr_pkg;

    // one pixel offered to the qualifier
    typedef struct packed {
        logic [31:0] srcPix;
        logic [31:0] dstPix;
        logic [11:0] x;
        logic [11:0] y;
        logic        isLine;
    } bkr_pix_s;

    // qualified result for that pixel
    typedef struct packed {
        logic [7:0]  rop;
        logic        write;
        logic [31:0] colour;
        logic        srcPass;
        logic        dstPass;
    } bkr_res_s;

    typedef enum logic [1:0] {
        BKR_IDLE,
        BKR_BUSY
    } bkr_state_e;

endpackage

`default_nettype wire

// *** verilog/bkr_pixel_qual.sv ***
// pixel qualification: colour keys, rop choice, clipping, line stipple
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bkr_consts.svh"

// Behaviour
// - non-mono source passes when within inclusive key bounds
// - destination passes when within inclusive key bounds
// - 8bpp palette index compared as one value
// - wider formats check R, G, B separately
// - 32bpp alpha byte ignored in key tests
// - disabled keying reports test failed
// - key results select rop0 to rop3
// - clip select picks set 0 or 1
// - key bounds hold 24 bits
// - pattern length 1 to 32, minus one
// - repeat 1 to 256 pixels, minus one
// - first bit covers repeat+1 minus fraction
// - pattern bits numbered lsb 0 up
// - style write reloads stipple position
// - idle style read returns next position
// - set bit foreground, else transparent or background
// - counter wraps at repeat, index at size
// - style fields repeat, size, fraction, integer
// - clip min inclusive, max exclusive
// - transparent command bit governs zero bits
module bkr_pixel_qual (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              lineStart,
    input  wire logic              lineEnd,
    input  wire logic              pixValid,
    input  wire bkr_pkg::bkr_pix_s pixIn,
    output bkr_pkg::bkr_res_s      resOut,
    output logic                   resValid,
    output logic                   engineBusy
);

    // register storage
    logic [31:0] clip0Lo_ff, clip0Hi_ff, clip1Lo_ff, clip1Hi_ff;
    logic [31:0] sKeyLo_ff, sKeyHi_ff, dKeyLo_ff, dKeyHi_ff;
    logic [31:0] rops_ff, style_ff, pattern_ff, fgCol_ff, bgCol_ff;
    logic [31:0] command_ff;
    logic [4:0]  bitPos_ff;
    logic [7:0]  pixPos_ff;
    bkr_pkg::bkr_state_e state_ff;

    // bus address phase capture
    logic        wrPend_ff;
    logic [7:0]  wrAddr_ff;
    logic        addrOk;
    logic        accept;
    logic [31:0] nxt_rdata;

    assign accept = hsel && hready && htrans[1];
    assign addrOk = (haddr[`BKR_A_PAGE] == 24'h000000);

    // slave always ready with zero wait states, always okay
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= `BKR_HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= `BKR_HRESP_OKAY;
        end
    end

    // write address is held so data lands in the following data phase
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 8'h00;
        end else if (hready) begin
            wrPend_ff <= accept && hwrite && addrOk;
            wrAddr_ff <= haddr[`BKR_A_OFFS];
        end
    end

    logic styleWr;
    assign styleWr = wrPend_ff && (wrAddr_ff == `BKR_A_STYLE);

    // register writes; reserved bits are masked so they read as zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clip0Lo_ff <= `BKR_ZERO32;
            clip0Hi_ff <= `BKR_ZERO32;
            clip1Lo_ff <= `BKR_ZERO32;
            clip1Hi_ff <= `BKR_ZERO32;
            sKeyLo_ff  <= `BKR_ZERO32;
            sKeyHi_ff  <= `BKR_ZERO32;
            dKeyLo_ff  <= `BKR_ZERO32;
            dKeyHi_ff  <= `BKR_ZERO32;
            rops_ff    <= `BKR_ZERO32;
            style_ff   <= `BKR_ZERO32;
            pattern_ff <= `BKR_ZERO32;
            fgCol_ff   <= `BKR_ZERO32;
            bgCol_ff   <= `BKR_ZERO32;
            command_ff <= `BKR_ZERO32;
        end else if (wrPend_ff) begin
            case (wrAddr_ff)
                `BKR_A_CLIP0LO: clip0Lo_ff <= hwdata & `BKR_CLIP_MASK;
                `BKR_A_CLIP0HI: clip0Hi_ff <= hwdata & `BKR_CLIP_MASK;
                `BKR_A_CLIP1LO: clip1Lo_ff <= hwdata & `BKR_CLIP_MASK;
                `BKR_A_CLIP1HI: clip1Hi_ff <= hwdata & `BKR_CLIP_MASK;
                `BKR_A_SKEYLO:  sKeyLo_ff  <= hwdata & `BKR_KEY_MASK;
                `BKR_A_SKEYHI:  sKeyHi_ff  <= hwdata & `BKR_KEY_MASK;
                `BKR_A_DKEYLO:  dKeyLo_ff  <= hwdata & `BKR_KEY_MASK;
                `BKR_A_DKEYHI:  dKeyHi_ff  <= hwdata & `BKR_KEY_MASK;
                `BKR_A_ROPS:    rops_ff    <= hwdata & `BKR_ROPS_MASK;
                `BKR_A_STYLE:   style_ff   <= hwdata & `BKR_ST_MASK;
                `BKR_A_PATTERN: pattern_ff <= hwdata;
                `BKR_A_FGCOL:   fgCol_ff   <= hwdata;
                `BKR_A_BGCOL:   bgCol_ff   <= hwdata;
                `BKR_A_COMMAND: command_ff <= hwdata & `BKR_CMD_MASK;
                default: ;
            endcase
        end
    end

    // engine busy between line start and line end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= bkr_pkg::BKR_IDLE;
        end else begin
            case (state_ff)
                bkr_pkg::BKR_IDLE: if (lineStart) begin
                    state_ff <= bkr_pkg::BKR_BUSY;
                end
                bkr_pkg::BKR_BUSY: if (lineEnd) begin
                    state_ff <= bkr_pkg::BKR_IDLE;
                end
                default: state_ff <= bkr_pkg::BKR_IDLE;
            endcase
        end
    end

    // read mux; style read shows the live position, valid while idle
    always_comb begin
        nxt_rdata = `BKR_ZERO32;
        case (haddr[`BKR_A_OFFS])
            `BKR_A_CLIP0LO: nxt_rdata = clip0Lo_ff;
            `BKR_A_CLIP0HI: nxt_rdata = clip0Hi_ff;
            `BKR_A_CLIP1LO: nxt_rdata = clip1Lo_ff;
            `BKR_A_CLIP1HI: nxt_rdata = clip1Hi_ff;
            `BKR_A_SKEYLO:  nxt_rdata = sKeyLo_ff;
            `BKR_A_SKEYHI:  nxt_rdata = sKeyHi_ff;
            `BKR_A_DKEYLO:  nxt_rdata = dKeyLo_ff;
            `BKR_A_DKEYHI:  nxt_rdata = dKeyHi_ff;
            `BKR_A_ROPS:    nxt_rdata = rops_ff;
            `BKR_A_STYLE: begin
                nxt_rdata = style_ff;
                nxt_rdata[`BKR_ST_FRAC] = pixPos_ff;
                nxt_rdata[`BKR_ST_INT]  = bitPos_ff;
            end
            `BKR_A_PATTERN: nxt_rdata = pattern_ff;
            `BKR_A_FGCOL:   nxt_rdata = fgCol_ff;
            `BKR_A_BGCOL:   nxt_rdata = bgCol_ff;
            `BKR_A_COMMAND: nxt_rdata = command_ff;
            `BKR_A_STATUS:  nxt_rdata = {31'h00000000,
                                         state_ff == bkr_pkg::BKR_BUSY};
            default:        nxt_rdata = `BKR_ZERO32;
        endcase
        if (!addrOk) begin
            nxt_rdata = `BKR_ZERO32;
        end
    end

    // read data registered at the end of the address phase
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hrdata <= `BKR_ZERO32;
        end else if (accept && !hwrite) begin
            hrdata <= nxt_rdata;
        end
    end

    // key range test; a channel check misses no wrap since bounds are per
    // channel, palette index is compared over the whole key field
    function automatic logic keyTest(
        input logic [31:0] pix,
        input logic [31:0] lo,
        input logic [31:0] hi,
        input logic        en,
        input logic [2:0]  fmt
    );
        logic inR;
        logic inG;
        logic inB;
        inR = (pix[`BKR_CH_R] >= lo[`BKR_CH_R]) &&
              (pix[`BKR_CH_R] <= hi[`BKR_CH_R]);
        inG = (pix[`BKR_CH_G] >= lo[`BKR_CH_G]) &&
              (pix[`BKR_CH_G] <= hi[`BKR_CH_G]);
        inB = (pix[`BKR_CH_B] >= lo[`BKR_CH_B]) &&
              (pix[`BKR_CH_B] <= hi[`BKR_CH_B]);
        if (!en) begin
            keyTest = 1'b0;
        end else if (fmt == `BKR_FMT_8BPP) begin
            keyTest = (pix[`BKR_KEY_VAL] >= lo[`BKR_KEY_VAL]) &&
                      (pix[`BKR_KEY_VAL] <= hi[`BKR_KEY_VAL]);
        end else begin
            keyTest = inR && inG && inB;
        end
    endfunction

    logic srcPass;
    logic dstPass;
    logic srcKeyEn;

    // monochrome source is never keyed, a guard against misprogramming
    assign srcKeyEn = command_ff[`BKR_CMD_SKEYEN] &&
                      (command_ff[`BKR_CMD_FMT] != `BKR_FMT_MONO);
    assign srcPass = keyTest(pixIn.srcPix, sKeyLo_ff, sKeyHi_ff, srcKeyEn,
                             command_ff[`BKR_CMD_FMT]);
    assign dstPass = keyTest(pixIn.dstPix, dKeyLo_ff, dKeyHi_ff,
                             command_ff[`BKR_CMD_DKEYEN],
                             command_ff[`BKR_CMD_FMT]);

    // rop choice from the two key results
    logic [7:0] ropSel;
    always_comb begin
        case ({srcPass, dstPass})
            2'b00:   ropSel = command_ff[`BKR_CMD_ROP0];
            2'b01:   ropSel = rops_ff[`BKR_ROP1];
            2'b10:   ropSel = rops_ff[`BKR_ROP2];
            default: ropSel = rops_ff[`BKR_ROP3];
        endcase
    end

    // clip window from the selected set
    logic [31:0] clipLo;
    logic [31:0] clipHi;
    logic        inClip;
    assign clipLo = command_ff[`BKR_CMD_CLIPSEL] ? clip1Lo_ff
                                                 : clip0Lo_ff;
    assign clipHi = command_ff[`BKR_CMD_CLIPSEL] ? clip1Hi_ff
                                                 : clip0Hi_ff;
    assign inClip = (pixIn.x >= clipLo[`BKR_CLIP_X]) &&
                    (pixIn.x <  clipHi[`BKR_CLIP_X]) &&
                    (pixIn.y >= clipLo[`BKR_CLIP_Y]) &&
                    (pixIn.y <  clipHi[`BKR_CLIP_Y]);

    // stipple colour for the current line pixel
    logic patBit;
    logic transpPix;
    assign patBit    = pattern_ff[bitPos_ff];
    assign transpPix = pixIn.isLine && !patBit &&
                       command_ff[`BKR_CMD_TRANSP];

    // stipple position; a style write wins over a pixel step, else the
    // position carries over from one line to the next
    logic lineStep;
    assign lineStep = pixValid && pixIn.isLine;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bitPos_ff <= 5'h00;
            pixPos_ff <= 8'h00;
        end else if (styleWr) begin
            bitPos_ff <= hwdata[`BKR_ST_INT];
            pixPos_ff <= hwdata[`BKR_ST_FRAC];
        end else if (lineStep) begin
            if (pixPos_ff == style_ff[`BKR_ST_REP]) begin
                pixPos_ff <= 8'h00;
                if (bitPos_ff == style_ff[`BKR_ST_SIZE]) begin
                    bitPos_ff <= 5'h00;
                end else begin
                    bitPos_ff <= bitPos_ff + 5'h01;
                end
            end else begin
                pixPos_ff <= pixPos_ff + 8'h01;
            end
        end
    end

    // registered result
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            resOut   <= '0;
            resValid <= 1'b0;
        end else begin
            resValid       <= pixValid;
            resOut.rop     <= ropSel;
            resOut.srcPass <= srcPass;
            resOut.dstPass <= dstPass;
            resOut.write   <= pixValid && inClip && !transpPix;
            if (pixIn.isLine) begin
                resOut.colour <= patBit ? fgCol_ff : bgCol_ff;
            end else begin
                resOut.colour <= pixIn.srcPix;
            end
        end
    end

    // busy flag for software, one cycle behind the state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            engineBusy <= 1'b0;
        end else begin
            engineBusy <= (state_ff == bkr_pkg::BKR_BUSY);
        end
    end

    // checks
    a_rop_both_fail: assert property (
        @(posedge sys_clk) disable iff (rst)
        pixValid && !srcPass && !dstPass
        |=> resOut.rop == $past(command_ff[`BKR_CMD_ROP0]))
        else $error("rop0 not chosen");
    a_rop_dst_only: assert property (
        @(posedge sys_clk) disable iff (rst)
        pixValid && !srcPass && dstPass
        |=> resOut.rop == $past(rops_ff[`BKR_ROP1]))
        else $error("rop1 not chosen");
    a_rop_src_only: assert property (
        @(posedge sys_clk) disable iff (rst)
        pixValid && srcPass && !dstPass
        |=> resOut.rop == $past(rops_ff[`BKR_ROP2]))
        else $error("rop2 not chosen");
    a_rop_both_pass: assert property (
        @(posedge sys_clk) disable iff (rst)
        pixValid && srcPass && dstPass
        |=> resOut.rop == $past(rops_ff[`BKR_ROP3]))
        else $error("rop3 not chosen");
    a_key_disabled: assert property (
        @(posedge sys_clk) disable iff (rst)
        !command_ff[`BKR_CMD_DKEYEN] |-> !dstPass)
        else $error("disabled key passed");
    a_clip_out: assert property (
        @(posedge sys_clk) disable iff (rst)
        pixValid && (pixIn.x >= clipHi[`BKR_CLIP_X]) |=> !resOut.write)
        else $error("pixel beyond clip written");
    a_transp_nowrite: assert property (
        @(posedge sys_clk) disable iff (rst)
        pixValid && transpPix |=> !resOut.write)
        else $error("transparent pixel written");
    a_line_fg: assert property (
        @(posedge sys_clk) disable iff (rst)
        pixValid && pixIn.isLine && patBit
        |=> resOut.colour == $past(fgCol_ff))
        else $error("set bit not foreground");
    a_style_reload: assert property (
        @(posedge sys_clk) disable iff (rst)
        styleWr |=> bitPos_ff == $past(hwdata[`BKR_ST_INT]) &&
                    pixPos_ff == $past(hwdata[`BKR_ST_FRAC]))
        else $error("style write did not reload");
    a_step_wrap: assert property (
        @(posedge sys_clk) disable iff (rst)
        lineStep && !styleWr && pixPos_ff == style_ff[`BKR_ST_REP] &&
        bitPos_ff == style_ff[`BKR_ST_SIZE]
        |=> bitPos_ff == 5'h00 && pixPos_ff == 8'h00)
        else $error("stipple did not wrap");
    a_step_count: assert property (
        @(posedge sys_clk) disable iff (rst)
        lineStep && !styleWr && pixPos_ff != style_ff[`BKR_ST_REP]
        |=> pixPos_ff == $past(pixPos_ff) + 8'h01 && $stable(bitPos_ff))
        else $error("stipple counter wrong");
    a_src_bounds: assert property (
        @(posedge sys_clk) disable iff (rst)
        srcPass && command_ff[`BKR_CMD_FMT] != `BKR_FMT_8BPP
        |-> srcKeyEn &&
            pixIn.srcPix[`BKR_CH_R] >= sKeyLo_ff[`BKR_CH_R] &&
            pixIn.srcPix[`BKR_CH_R] <= sKeyHi_ff[`BKR_CH_R] &&
            pixIn.srcPix[`BKR_CH_G] >= sKeyLo_ff[`BKR_CH_G] &&
            pixIn.srcPix[`BKR_CH_G] <= sKeyHi_ff[`BKR_CH_G] &&
            pixIn.srcPix[`BKR_CH_B] >= sKeyLo_ff[`BKR_CH_B] &&
            pixIn.srcPix[`BKR_CH_B] <= sKeyHi_ff[`BKR_CH_B])
        else $error("source passed outside its bounds");

    c_both_pass: cover property (@(posedge sys_clk)
        pixValid && srcPass && dstPass);
    c_transp: cover property (@(posedge sys_clk) pixValid && transpPix);
    c_wrap: cover property (@(posedge sys_clk)
        lineStep && bitPos_ff == style_ff[`BKR_ST_SIZE] &&
        pixPos_ff == style_ff[`BKR_ST_REP]);
    c_clip1: cover property (@(posedge sys_clk)
        pixValid && command_ff[`BKR_CMD_CLIPSEL] && inClip);

endmodule

`default_nettype wire

// *** dv/bkr_pixel_qual_bench.sv ***
// self-checking bench for the key, rop, clip and stipple block
`timescale 1ns/1ps
`default_nettype none
`include "bkr_consts.svh"
module bkr_pixel_qual_bench;
    logic              sys_clk = 1'h0;
    logic              rst = 1'h1;
    logic              hsel = 1'h0;
    logic [31:0]       haddr = 32'h0;
    logic [1:0]        htrans = 2'h0;
    logic              hwrite = 1'h0;
    logic [2:0]        hsize = 3'h2;
    logic [31:0]       hwdata = 32'h0;
    logic [31:0]       hrdata;
    logic              hreadyout;
    logic              hresp;
    logic              lineStart = 1'h0;
    logic              lineEnd = 1'h0;
    logic              pixValid = 1'h0;
    bkr_pkg::bkr_pix_s pixIn = '0;
    bkr_pkg::bkr_res_s resOut;
    logic              resValid;
    logic              engineBusy;
    int                fails = 0;
    int                samples_checked = 0;
    logic [31:0]       rd;
    logic [31:0]       sty;
    logic [31:0]       pat;
    logic [4:0]        bitPos;
    logic [7:0]        pixPos;
    localparam logic [7:0] ROPX [4] = '{8'hCC, 8'h11, 8'h22, 8'h33};
    localparam logic [31:0] FG = 32'h00AABBCC;
    localparam logic [31:0] BG = 32'h00112233;
    // clip cases: [28] select, [24] expected write, [23:12] x, [11:0] y
    localparam logic [31:0] CT [8] = '{
        32'h01003002, 32'h01008007, 32'h00009002, 32'h00002002,
        32'h00003008, 32'h00003001, 32'h11000000, 32'h10001000};

    // hready is the single slave's own hreadyout
    bkr_pixel_qual bkr_pixel_qual_i (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .hsel       (hsel),
        .haddr      (haddr),
        .htrans     (htrans),
        .hwrite     (hwrite),
        .hsize      (hsize),
        .hwdata     (hwdata),
        .hready     (hreadyout),
        .hrdata     (hrdata),
        .hreadyout  (hreadyout),
        .hresp      (hresp),
        .lineStart  (lineStart),
        .lineEnd    (lineEnd),
        .pixValid   (pixValid),
        .pixIn      (pixIn),
        .resOut     (resOut),
        .resValid   (resValid),
        .engineBusy (engineBusy)
    );

    // 100 ns period
    always #50 sys_clk = ~sys_clk;

    task automatic close_out();
        if (fails == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // one single transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'h1);
        rd = hrdata;
        chk(32'(hresp), 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'h1, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'h0, 32'h0);
        chk(rd, e);
    endtask

    // a pixel is offered for one cycle, its result is read a cycle later
    task automatic px(input logic [31:0] s, input logic [31:0] d,
                      input logic [11:0] x, input logic [11:0] y,
                      input logic ln);
        @(posedge sys_clk);
        pixValid <= 1'h1;
        pixIn <= {s, d, x, y, ln};
        @(posedge sys_clk);
        pixValid <= 1'h0;
        #1;
        chk(32'(resValid), 32'h1);
    endtask

    task automatic key(input logic [31:0] s, input logic [31:0] d,
                       input logic [1:0] p);
        px(s, d, 12'h4, 12'h4, 1'h0);
        chk({22'h0, resOut.srcPass, resOut.dstPass, resOut.rop},
            {22'h0, p, ROPX[p]});
        chk(resOut.colour, s);
    endtask

    // reloading the style also reloads the model's position
    task automatic style(input logic [31:0] v);
        wr(`BKR_A_STYLE, v);
        sty = v;
        bitPos = v[28:24];
        pixPos = v[23:16];
    endtask

    // a line of n pixels checked against a reference stipple walk
    task automatic line(input int n, input logic tr);
        logic vis;
        wr(`BKR_A_COMMAND, {20'h0, tr, 11'h0CC} | 32'h00005000);
        @(posedge sys_clk);
        lineStart <= 1'h1;
        @(posedge sys_clk);
        lineStart <= 1'h0;
        rc(`BKR_A_STATUS, 32'h1);
        for (int i = 0; i < n; i++) begin
            px(32'h0, 32'h0, 12'h4, 12'h4, 1'h1);
            vis = pat[bitPos] | ~tr;
            chk(32'(resOut.write), 32'(vis));
            if (vis)
                chk(resOut.colour, pat[bitPos] ? FG : BG);
            if (pixPos == sty[7:0]) begin
                pixPos = 8'h0;
                bitPos = (bitPos == sty[12:8]) ? 5'h0 : bitPos + 5'h1;
            end else begin
                pixPos = pixPos + 8'h1;
            end
        end
        @(posedge sys_clk);
        lineEnd <= 1'h1;
        @(posedge sys_clk);
        lineEnd <= 1'h0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(32'(engineBusy), 32'h0);
        rc(`BKR_A_STYLE, {3'h0, bitPos, pixPos, sty[15:0]});
    endtask

    // cut a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        close_out();
    end

    // main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'h0;
        rc(`BKR_A_STYLE, 32'h0);
        rc(`BKR_A_CLIP1HI, 32'h0);
        wr(`BKR_A_SKEYLO, 32'hFFFFFFFF);
        rc(`BKR_A_SKEYLO, 32'h00FFFFFF);
        wr(`BKR_A_CLIP1LO, 32'hFFFFFFFF);
        rc(`BKR_A_CLIP1LO, 32'h0FFF0FFF);
        wr(`BKR_A_STYLE, 32'hFFFFFFFF);
        rc(`BKR_A_STYLE, 32'h1FFF1FFF);
        wr(8'h3C, 32'h12345678);
        rc(8'h3C, 32'h0);
        // clip windows: min inclusive, max exclusive, per select bit
        wr(`BKR_A_CLIP0LO, 32'h00020003);
        wr(`BKR_A_CLIP0HI, 32'h00080009);
        wr(`BKR_A_CLIP1LO, 32'h00000000);
        wr(`BKR_A_CLIP1HI, 32'h00010001);
        foreach (CT[i]) begin
            wr(`BKR_A_COMMAND, {21'h0, CT[i][28], 10'h0});
            px(32'h0, 32'h0, CT[i][23:12], CT[i][11:0], 1'h0);
            chk(32'(resOut.write), 32'(CT[i][24]));
        end
        // channel keys in a 32 bpp format, both surfaces keyed
        wr(`BKR_A_SKEYLO, 32'h00102030);
        wr(`BKR_A_SKEYHI, 32'h00405060);
        wr(`BKR_A_DKEYLO, 32'h00000000);
        wr(`BKR_A_DKEYHI, 32'h00101010);
        wr(`BKR_A_ROPS, 32'h00332211);
        wr(`BKR_A_COMMAND, 32'h000053CC);
        key(32'hFF102030, 32'h00101010, 2'h3);
        key(32'h00405060, 32'h00101011, 2'h2);
        key(32'h00405061, 32'hFF000000, 2'h1);
        key(32'h000F3040, 32'h00111010, 2'h0);
        key(32'h00407060, 32'h00001000, 2'h1);
        key(32'h00304050, 32'h00000011, 2'h2);
        // keying off reports failure whatever the pixel
        wr(`BKR_A_COMMAND, 32'h000050CC);
        key(32'h00304050, 32'h00000000, 2'h0);
        wr(`BKR_A_COMMAND, 32'h000052CC);
        key(32'h00304050, 32'h00000000, 2'h1);
        // palette index compared as a single scalar
        wr(`BKR_A_SKEYLO, 32'h00000010);
        wr(`BKR_A_SKEYHI, 32'h00010020);
        wr(`BKR_A_COMMAND, 32'h000013CC);
        key(32'h00000105, 32'h00000000, 2'h3);
        key(32'h0000000F, 32'h00000000, 2'h1);
        // stipple walk, then a second line that carries on
        wr(`BKR_A_PATTERN, 32'h000002B7);
        wr(`BKR_A_FGCOL, FG);
        wr(`BKR_A_BGCOL, BG);
        pat = 32'h000002B7;
        style(32'h07020904);
        rc(`BKR_A_STYLE, 32'h07020904);
        line(12, 1'h0);
        line(20, 1'h1);
        style(32'h00000301);
        line(10, 1'h0);
        // full 32-bit pattern wraps from bit 31 to bit 0
        pat = 32'h80000001;
        wr(`BKR_A_PATTERN, pat);
        style(32'h1F001F00);
        line(4, 1'h0);
        // 256 pixels a bit, first bit shortened by the fraction
        pat = 32'h00000001;
        wr(`BKR_A_PATTERN, pat);
        style(32'h00FE01FF);
        line(5, 1'h0);
        close_out();
    end

endmodule
`default_nettype wire
